// file: core/rtdsc_pkg.sv
// rtdsc_pkg: register map, field layout, limits and timing for the rtd scan control
// assumes a 50 MHz clock and a word-indexed register port of 4 address bits
package rtdsc_pkg;

   localparam int NCH = 4;

   // register word indices
   localparam logic [3:0] ADDR_CFG0 = 4'h0;
   localparam logic [3:0] ADDR_CTRL = 4'h4;
   localparam logic [3:0] ADDR_IRQ_STAT = 4'h5;
   localparam logic [3:0] ADDR_IRQ_MASK = 4'h6;
   localparam logic [3:0] ADDR_DATA0 = 4'h8;
   localparam logic [3:0] ADDR_CHST0 = 4'hC;

   // channel config byte
   localparam int CFG_EN_BIT = 0;
   localparam int CFG_KIND_BIT = 1;
   localparam int CFG_RNG_LSB = 2;
   localparam int CFG_RNG_MSB = 4;
   localparam logic [7:0] CFG_RST = 8'h00;

   // control word
   localparam int CTRL_CYC_BIT = 0;

   // channel status bits
   localparam int FLT_OVER = 0;
   localparam int FLT_UNDER = 1;
   localparam int FLT_SHORT = 2;
   localparam int FLT_OPEN = 3;
   localparam int FLT_CFG = 4;

   // interrupt status bits
   localparam int IRQ_CFG = 0;
   localparam int IRQ_FAULT = 1;
   localparam int IRQ_TEST = 2;
   localparam int IRQ_CAL = 3;
   localparam logic [3:0] IRQ_MASK_RST = 4'h0;

   // converter codes
   localparam logic [15:0] RES_OPEN = 16'hFFFF;
   localparam logic [15:0] SHORT_LIM = 16'h0005;
   localparam logic [15:0] CAL_REF = 16'h4000;
   localparam logic [15:0] MEM_PAT = 16'hA5C3;

   // range limits, element n is range code n
   localparam logic [3:0][15:0] RTD_LO = {16'hFC18, 16'hFCE0, 16'hF830, 16'hF830};
   localparam logic [3:0][15:0] RTD_HI = {16'h07D0, 16'h0A28, 16'h189C, 16'h2134};
   localparam logic [3:0][15:0] RES_LO = {16'h0000, 16'h0000, 16'h0000, 16'h0000};
   localparam logic [3:0][15:0] RES_HI = {16'h7530, 16'h2710, 16'h1388, 16'h3A98};

   // timing
   localparam longint unsigned CLK_HZ = 64'd50_000_000;
   localparam longint unsigned CAL_PERIOD_MIN = 64'd5;
   localparam longint unsigned CAL_PERIOD_CYC = CAL_PERIOD_MIN * 64'd60 * CLK_HZ;
   localparam longint unsigned COMM_TIMEOUT_MS = 64'd100;
   localparam longint unsigned COMM_TIMEOUT_CYC = COMM_TIMEOUT_MS * CLK_HZ / 64'd1000;
   localparam longint unsigned SELFTEST_US = 64'd10;
   localparam int SELFTEST_CYC = int'(SELFTEST_US * CLK_HZ / 64'd1_000_000);
   localparam int ST_W = $clog2(SELFTEST_CYC);

   typedef enum logic [2:0] {
      ST_TEST = 3'h0,
      ST_FAIL = 3'h1,
      ST_WAIT = 3'h2,
      ST_PICK = 3'h3,
      ST_CONV = 3'h4,
      ST_CHECK = 3'h5
   } rtdsc_state_t;

   function automatic logic rtdsc_cfg_ok(input logic [7:0] c);
      return !c[CFG_RNG_MSB];
   endfunction

   function automatic logic rtdsc_run(input logic [7:0] c);
      return c[CFG_EN_BIT] && !c[CFG_RNG_MSB];
   endfunction

endpackage

// file: core/rtdsc_chk_if.sv
// rtdsc_chk_if: one reading handed from the scan control to the reading checker
// assumes both ends share the core clock
`timescale 1ns/1ps
interface rtdsc_chk_if;
   logic req;
   logic kind;
   logic [1:0] rng;
   logic [15:0] res;
   logic [15:0] lead;
   logic [15:0] offs;
   logic valid;
   logic [15:0] value;
   logic [3:0] flt;

   modport core (output req, kind, rng, res, lead, offs, input valid, value, flt);
   modport chk (input req, kind, rng, res, lead, offs, output valid, value, flt);
endinterface

// file: core/rtdsc_chk.sv
// rtdsc_chk: compensates one reading and tests it for range and wiring faults
// assumes req is a one-cycle pulse with the reading held steady beside it
`timescale 1ns/1ps
module rtdsc_chk import rtdsc_pkg::*; (
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // reading in, verdict out
   rtdsc_chk_if.chk bus
);

   typedef struct packed {
      logic valid;
      logic [15:0] value;
      logic [3:0] flt;
   } rtdsc_chk_st_t;

   rtdsc_chk_st_t s;
   rtdsc_chk_st_t next_s;
   logic [15:0] net;
   logic [15:0] comp;
   logic [15:0] lo;
   logic [15:0] hi;

   // lead resistance removed, then calibration offset
   assign net = bus.res - bus.lead;
   assign comp = net - bus.offs;
   assign lo = bus.kind ? RES_LO[bus.rng] : RTD_LO[bus.rng];
   assign hi = bus.kind ? RES_HI[bus.rng] : RTD_HI[bus.rng];

   always_comb begin
      next_s = s;
      next_s.valid = bus.req;
      if (bus.req) begin
         next_s.value = comp;
         next_s.flt[FLT_OVER] = $signed(comp) > $signed(hi);
         next_s.flt[FLT_UNDER] = $signed(comp) < $signed(lo);
         next_s.flt[FLT_OPEN] = bus.res == RES_OPEN;
         next_s.flt[FLT_SHORT] = bus.res != RES_OPEN && net < SHORT_LIM;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   assign bus.valid = s.valid;
   assign bus.value = s.value;
   assign bus.flt = s.flt;

   a_open_flag: assert property (@(posedge clk) disable iff (!rst_n)
      bus.req && bus.res == RES_OPEN |=> bus.valid && bus.flt[FLT_OPEN])
      else $error("open input not flagged");

endmodule // rtdsc_chk

// file: core/rtdsc_core.sv
// rtdsc_core: self-test, configuration, channel scan, calibration and comm watchdog
// assumes a synchronous register port and an external converter with a done pulse
//
// Chosen here: the address-and-strobe port and the register addresses.
`timescale 1ns/1ps
module rtdsc_core import rtdsc_pkg::*; #(
   parameter longint unsigned CAL_PERIOD = CAL_PERIOD_CYC,
   parameter longint unsigned COMM_TIMEOUT = COMM_TIMEOUT_CYC
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // register port
   input wire logic [3:0] addr,
   input wire logic [15:0] wdata,
   input wire logic wr,
   input wire logic rd,
   output logic [15:0] rdata,
   // converter
   output logic conv_start,
   output logic conv_cal,
   output logic [1:0] conv_mux,
   input wire logic conv_done,
   input wire logic [15:0] conv_res,
   input wire logic [15:0] conv_lead,
   // front end health and indicators
   input wire logic afe_ok,
   output logic status_led,
   output logic proc_rst,
   output logic irq
);

   localparam int CAL_W = $clog2(CAL_PERIOD + 64'd1);
   localparam int WD_W = $clog2(COMM_TIMEOUT + 64'd1);
   localparam logic [CAL_W-1:0] CAL_LAST = CAL_W'(CAL_PERIOD - 64'd1);
   localparam logic [WD_W-1:0] WD_LAST = WD_W'(COMM_TIMEOUT - 64'd1);
   localparam logic [ST_W-1:0] ST_LAST = ST_W'(SELFTEST_CYC - 1);

   typedef struct packed {
      rtdsc_state_t st;
      logic [ST_W-1:0] cnt;
      logic mem_ok;
      logic [1:0] ch;
      logic cyc_en;
      logic [3:0] irq_stat;
      logic [3:0] irq_mask;
      logic [NCH-1:0][7:0] cfg;
      logic [NCH-1:0][15:0] data;
      logic [NCH-1:0][4:0] chst;
      logic [NCH-1:0][15:0] offs;
      logic [NCH-1:0] cal_pend;
      logic [15:0] res;
      logic [15:0] lead;
      logic [CAL_W-1:0] cal_tmr;
      logic [WD_W-1:0] wd;
      logic proc_rst;
      logic led;
      logic irq;
      logic [15:0] rdata;
      logic conv_start;
      logic conv_cal;
      logic chk_req;
   } rtdsc_core_st_t;

   rtdsc_core_st_t s;
   rtdsc_core_st_t next_s;
   logic [3:0] ev;
   logic [3:0] clr;
   logic [1:0] wi;

   rtdsc_chk_if chk_bus ();

   assign chk_bus.req = s.chk_req;
   assign chk_bus.kind = s.cfg[s.ch][CFG_KIND_BIT];
   assign chk_bus.rng = s.cfg[s.ch][CFG_RNG_LSB+1:CFG_RNG_LSB];
   assign chk_bus.res = s.res;
   assign chk_bus.lead = s.lead;
   assign chk_bus.offs = s.offs[s.ch];

   rtdsc_chk u_chk (
      .clk(clk),
      .rst_n(rst_n),
      .bus(chk_bus.chk)
   );

   assign wi = addr[1:0];

   always_comb begin
      next_s = s;
      ev = '0;
      clr = '0;
      next_s.conv_start = 1'b0;
      next_s.chk_req = 1'b0;
      next_s.rdata = '0;
      unique case (s.st)
         ST_TEST: begin
            next_s.cnt = s.cnt + 1'b1;
            // write then read back a pattern in the result store
            if (s.cnt < ST_W'(NCH)) begin
               next_s.data[s.cnt[1:0]] = MEM_PAT ^ {14'h0000, s.cnt[1:0]};
            end else if (s.cnt < ST_W'(2 * NCH)) begin
               if (s.data[s.cnt[1:0]] != (MEM_PAT ^ {14'h0000, s.cnt[1:0]})) begin
                  next_s.mem_ok = 1'b0;
               end
            end
            if (s.cnt == ST_LAST) begin
               next_s.cnt = '0;
               next_s.data = '0;
               if (s.mem_ok && afe_ok) begin
                  next_s.st = ST_WAIT;
                  next_s.led = 1'b1;
               end else begin
                  next_s.st = ST_FAIL;
                  ev[IRQ_TEST] = 1'b1;
               end
            end
         end
         ST_FAIL: begin
            next_s.led = 1'b0;
         end
         ST_WAIT: begin
            next_s.led = 1'b1;
         end
         ST_PICK: begin
            if (rtdsc_run(s.cfg[s.ch]) && s.cal_pend[s.ch]) begin
               next_s.conv_start = 1'b1;
               next_s.conv_cal = 1'b1;
               next_s.st = ST_CONV;
            end else if (rtdsc_run(s.cfg[s.ch])) begin
               next_s.conv_start = 1'b1;
               next_s.conv_cal = 1'b0;
               next_s.st = ST_CONV;
            end else begin
               next_s.ch = s.ch + 1'b1;
            end
         end
         ST_CONV: begin
            if (conv_done) begin
               if (s.conv_cal) begin
                  // reference reading gives the offset for this channel
                  next_s.offs[s.ch] = conv_res - CAL_REF;
                  next_s.cal_pend[s.ch] = 1'b0;
                  next_s.conv_cal = 1'b0;
                  ev[IRQ_CAL] = 1'b1;
                  next_s.st = ST_PICK;
               end else begin
                  next_s.res = conv_res;
                  next_s.lead = conv_lead;
                  next_s.chk_req = 1'b1;
                  next_s.st = ST_CHECK;
               end
            end
         end
         ST_CHECK: begin
            if (chk_bus.valid) begin
               if (rtdsc_run(s.cfg[s.ch])) begin
                  next_s.data[s.ch] = chk_bus.value;
                  next_s.chst[s.ch][3:0] = chk_bus.flt;
                  ev[IRQ_FAULT] = |chk_bus.flt;
               end
               next_s.ch = s.ch + 1'b1;
               next_s.st = ST_PICK;
            end
         end
         default: begin
            next_s.st = ST_TEST;
         end
      endcase

      // register writes, after the scan so a disable wins
      if (wr) begin
         if (addr < ADDR_CTRL) begin
            next_s.cfg[wi] = wdata[7:0];
            if (!wdata[CFG_EN_BIT]) begin
               next_s.chst[wi] = '0;
               next_s.cal_pend[wi] = 1'b0;
            end else if (!s.cfg[wi][CFG_EN_BIT] || !rtdsc_cfg_ok(s.cfg[wi])) begin
               next_s.cal_pend[wi] = 1'b1;
            end
            if (rtdsc_cfg_ok(wdata[7:0])) begin
               next_s.chst[wi][FLT_CFG] = 1'b0;
               if (s.st == ST_WAIT) begin
                  next_s.st = ST_PICK;
               end
            end else begin
               next_s.chst[wi][FLT_CFG] = 1'b1;
               ev[IRQ_CFG] = 1'b1;
            end
         end else if (addr == ADDR_CTRL) begin
            next_s.cyc_en = wdata[CTRL_CYC_BIT];
         end else if (addr == ADDR_IRQ_STAT) begin
            clr = wdata[3:0];
         end else if (addr == ADDR_IRQ_MASK) begin
            next_s.irq_mask = wdata[3:0];
         end
      end

      // register reads, answered in the next cycle only
      if (rd) begin
         if (addr < ADDR_CTRL) begin
            next_s.rdata = {8'h00, s.cfg[wi]};
         end else if (addr == ADDR_CTRL) begin
            next_s.rdata = {11'h000, s.st, s.led, s.cyc_en};
         end else if (addr == ADDR_IRQ_STAT) begin
            next_s.rdata = {12'h000, s.irq_stat};
         end else if (addr == ADDR_IRQ_MASK) begin
            next_s.rdata = {12'h000, s.irq_mask};
         end else if (addr >= ADDR_DATA0 && addr < ADDR_CHST0) begin
            next_s.rdata = s.data[wi];
         end else if (addr >= ADDR_CHST0) begin
            next_s.rdata = {11'h000, s.chst[wi]};
         end
      end

      // periodic recalibration of every running channel
      if (!s.cyc_en) begin
         next_s.cal_tmr = '0;
      end else if (s.cal_tmr == CAL_LAST) begin
         next_s.cal_tmr = '0;
         for (int i = 0; i < NCH; i++) begin
            if (rtdsc_run(next_s.cfg[i])) begin
               next_s.cal_pend[i] = 1'b1;
            end
         end
      end else begin
         next_s.cal_tmr = s.cal_tmr + 1'b1;
      end

      // bus silence watchdog
      if (wr || rd) begin
         next_s.wd = '0;
      end else if (s.wd != WD_LAST) begin
         next_s.wd = s.wd + 1'b1;
      end
      next_s.proc_rst = next_s.wd == WD_LAST;

      // sticky events, a set wins over a clear
      next_s.irq_stat = (s.irq_stat & ~clr) | ev;
      next_s.irq = |(next_s.irq_stat & next_s.irq_mask);
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         s <= '0;
         s.st <= ST_TEST;
         s.mem_ok <= 1'b1;
         s.irq_mask <= IRQ_MASK_RST;
         s.cfg <= {NCH{CFG_RST}};
      end else begin
         s <= next_s;
      end
   end

   assign rdata = s.rdata;
   assign conv_start = s.conv_start;
   assign conv_cal = s.conv_cal;
   assign conv_mux = s.ch;
   assign status_led = s.led;
   assign proc_rst = s.proc_rst;
   assign irq = s.irq;

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_n);

   a_led_dark_test: assert property (s.st == ST_TEST |-> !status_led)
      else $error("indicator lit during self-test");
   a_test_fail_dark: assert property (
      s.st == ST_TEST && s.cnt == ST_LAST && !afe_ok |=> s.st == ST_FAIL && !status_led)
      else $error("failed self-test not held");
   a_no_conv_idle: assert property (
      s.st inside {ST_TEST, ST_FAIL, ST_WAIT} |-> !conv_start && !s.chk_req)
      else $error("conversion before valid configuration");
   a_cfg_err_flag: assert property (
      wr && addr < ADDR_CTRL && wdata[CFG_RNG_MSB] |=> s.irq_stat[IRQ_CFG] && s.chst[$past(wi)][FLT_CFG])
      else $error("invalid configuration not flagged");
   a_fault_bits_set: assert property (
      s.st == ST_CHECK && chk_bus.valid && rtdsc_run(s.cfg[s.ch]) && !wr
      |=> s.chst[$past(s.ch)][3:0] == $past(chk_bus.flt))
      else $error("fault bits not stored");
   a_data_loaded: assert property (
      s.st == ST_CHECK && chk_bus.valid && rtdsc_run(s.cfg[s.ch])
      |=> s.data[$past(s.ch)] == $past(chk_bus.value))
      else $error("result word not stored");
   a_cal_first: assert property (conv_start && !conv_cal |-> !$past(s.cal_pend[s.ch]))
      else $error("channel converted before calibration");
   a_disable_clears: assert property (
      wr && addr < ADDR_CTRL && !wdata[CFG_EN_BIT] && !wdata[CFG_RNG_MSB] |=> s.chst[$past(wi)] == '0)
      else $error("disabled channel keeps fault bits");
   a_wd_fire: assert property (proc_rst |-> s.wd == WD_LAST)
      else $error("processor reset without bus silence");
   a_wd_release: assert property ((wr || rd) |=> !proc_rst)
      else $error("processor reset despite bus traffic");
   a_cyc_wrap: assert property (s.cyc_en && s.cal_tmr == CAL_LAST && !wr |=> s.cal_tmr == '0)
      else $error("calibration period not restarted");
   a_rdata_quiet: assert property (!$past(rd) |-> rdata == '0)
      else $error("read data outside answer cycle");

   c_reading: cover property (s.st == ST_CHECK && chk_bus.valid);
   c_calib: cover property (conv_start && conv_cal);
   c_cfg_err: cover property (wr && addr < ADDR_CTRL && wdata[CFG_RNG_MSB]);
   c_watchdog: cover property ($rose(proc_rst));

endmodule // rtdsc_core

// file: tb/rtdsc_conv_model.sv
// rtdsc_conv_model: behavioural converter that answers the scan control
// assumes the bench loads res_tab, lead_tab and lat by hierarchical reference
`timescale 1ns/1ps
module rtdsc_conv_model import rtdsc_pkg::*; #(
   parameter logic [15:0] CAL_OFS = 16'h1000
) (
   // clock
   input wire logic clk,
   // request
   input wire logic conv_start,
   input wire logic conv_cal,
   input wire logic [1:0] conv_mux,
   // answer
   output logic conv_done,
   output logic [15:0] conv_res,
   output logic [15:0] conv_lead
);
   logic [15:0] res_tab [4] = '{default: 16'h0000};
   logic [15:0] lead_tab [4] = '{default: 16'h0000};
   int lat = 3;
   int cnt = -1;
   logic cal_q = 1'b0;
   logic [1:0] ch_q = 2'h0;

   always @(posedge clk) begin
      conv_done <= 1'b0;
      // readings are stale outside the answer cycle
      conv_res <= ~conv_res;
      conv_lead <= ~conv_lead;
      if (conv_start === 1'b1) begin
         cal_q <= conv_cal;
         ch_q <= conv_mux;
         cnt <= lat;
      end else if (cnt == 0) begin
         conv_done <= 1'b1;
         conv_res <= cal_q ? CAL_REF + CAL_OFS : res_tab[ch_q];
         conv_lead <= cal_q ? 16'h0000 : lead_tab[ch_q];
         cnt <= -1;
      end else if (cnt > 0) begin
         cnt <= cnt - 1;
      end
   end
endmodule // rtdsc_conv_model

// file: tb/tb_rtd_channel_scan_control.sv
// tb_rtd_channel_scan_control: self-checking bench for the rtd scan control
// assumes rtdsc_core with shortened timers and the converter model
`timescale 1ns/1ps
module tb_rtd_channel_scan_control import rtdsc_pkg::*; ();
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic [3:0] addr = 4'h0;
   logic [15:0] wdata = 16'h0000;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic afe_ok = 1'b1;
   logic [15:0] rdata, conv_res, conv_lead, q;
   logic conv_start, conv_cal, conv_done, status_led, proc_rst, irq;
   logic [1:0] conv_mux;
   int n_fail = 0;
   int n_tests = 0;
   int seed = 41354;
   int n_cal = 0;
   int c, kind, rng, v;
   bit quiet = 1'b1;
   bit [3:0] seen = 4'h0;
   int dv [7] = '{-1, 4, 5, 2095, 2096, 12596, 12597};

   always #10 clk = ~clk;

   rtdsc_core #(.CAL_PERIOD(200), .COMM_TIMEOUT(300)) u_dut (.clk(clk), .rst_n(rst_n),
      .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .conv_start(conv_start),
      .conv_cal(conv_cal), .conv_mux(conv_mux), .conv_done(conv_done), .conv_res(conv_res),
      .conv_lead(conv_lead), .afe_ok(afe_ok), .status_led(status_led), .proc_rst(proc_rst),
      .irq(irq));

   rtdsc_conv_model u_conv (.clk(clk), .conv_start(conv_start), .conv_cal(conv_cal),
      .conv_mux(conv_mux), .conv_done(conv_done), .conv_res(conv_res), .conv_lead(conv_lead));

   task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string m);
      n_tests++;
      if (got !== exp) begin
         n_fail++;
         $display("wrong value at %0t: %s got %h exp %h", $time, m, got, exp);
      end
   endtask

   task automatic give_verdict();
      $display("comparisons %0d mismatches %0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   task automatic wreg(input logic [3:0] a, input logic [15:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask

   task automatic rreg(input logic [3:0] a, output logic [15:0] d);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1;
      d = rdata;
   endtask

   function automatic int lim(input int k, input int r, input bit top);
      logic [15:0] x;
      x = top ? (k ? RES_HI[r] : RTD_HI[r]) : (k ? RES_LO[r] : RTD_LO[r]);
      return int'($signed(x));
   endfunction

   // d is res minus lead, negative means open input
   task automatic meas(input int ch, input int d, input int k, input int r);
      int lead, val, m;
      logic [4:0] f;
      lead = $random(seed) & 63;
      u_conv.res_tab[ch] = (d < 0) ? 16'hFFFF : 16'(d + lead);
      u_conv.lead_tab[ch] = 16'(lead);
      repeat (2) begin
         m = 0;
         do begin
            @(posedge clk);
            #1;
            m++;
         end while (m < 3000 && !(conv_done === 1'b1 && conv_mux === ch[1:0] && conv_cal === 1'b0));
         if (m >= 3000) chk(16'h1, 16'h0, "no conversion");
      end
      val = d - 4096;
      f = {1'b0, d < 0, d >= 0 && d < 5, val < lim(k, r, 0), val > lim(k, r, 1)};
      repeat (4) @(posedge clk);
      rreg(ADDR_CHST0 + 4'(ch), q);
      if (d < 0) chk(q[3:2], 2'b10, "open flag");
      else chk(q, {11'h0, f}, "status word");
      if (f[3:2] == 2'b00) begin
         rreg(ADDR_DATA0 + 4'(ch), q);
         chk(q, 16'(val), "result word");
      end
   endtask

   always @(posedge clk) begin
      if (conv_start === 1'b1) begin
         chk(16'(quiet), 16'h0, "conversion before a valid config");
         chk(16'(conv_mux == 2'd3), 16'h0, "disabled channel converted");
         if (!seen[conv_mux]) begin
            seen[conv_mux] = 1'b1;
            chk(16'(conv_cal), 16'h1, "first conversion not a calibration");
         end
         if (conv_cal) n_cal++;
      end
   end

   initial begin
      fork
         begin
            #400_000;
            n_fail++;
            $display("wrong value at %0t: run hung", $time);
            give_verdict();
         end
      join_none
      repeat (8) @(posedge clk);
      rst_n <= 1'b1;
      rreg(ADDR_CTRL, q);
      chk(q[4:1], 4'h0, "testing with dark indicator");
      repeat (500) @(posedge clk);
      #1;
      chk(status_led, 1'b1, "indicator after clean self-test");
      rreg(ADDR_CTRL, q);
      chk(q[4:1], 4'h5, "waiting with indicator on");
      wreg(4'h7, 16'hFFFF);
      rreg(4'h7, q);
      chk(q, 16'h0000, "unmapped read");
      wreg(ADDR_CFG0 + 4'h1, 16'h0010);
      rreg(ADDR_IRQ_STAT, q);
      chk(q[IRQ_CFG], 1'b1, "config error event");
      rreg(ADDR_CHST0 + 4'h1, q);
      chk(q[FLT_CFG], 1'b1, "config error status");
      chk(irq, 1'b0, "masked interrupt");
      wreg(ADDR_IRQ_MASK, 16'h0001);
      repeat (2) @(posedge clk);
      #1;
      chk(irq, 1'b1, "unmasked interrupt");
      wreg(ADDR_IRQ_STAT, 16'h0001);
      #1;
      chk(irq, 1'b0, "cleared interrupt");
      wreg(ADDR_IRQ_MASK, 16'h0000);
      quiet = 1'b0;
      wreg(ADDR_CFG0, 16'h0001);
      wreg(ADDR_CFG0 + 4'h2, 16'h0007);
      foreach (dv[i]) meas(0, dv[i], 0, 0);
      for (int r = 0; r < 8; r++) begin
         kind = r & 1;
         rng = r >> 1;
         u_conv.lat = kind ? 12 : 0;
         wreg(ADDR_CFG0 + 4'h1, 16'(1 | kind << 1 | rng << 2));
         c = lim(kind, rng, 1) - lim(kind, rng, 0) + 1;
         v = lim(kind, rng, 0) + (($random(seed) & 32'h7FFFFFFF) % c);
         meas(1, v + 4096, kind, rng);
         meas(2, 4100 + ($random(seed) & 16'h0FFF), 1, 1);
      end
      rreg(ADDR_IRQ_STAT, q);
      chk(q[3:0], 4'hA, "fault and calibration events");
      chk(irq, 1'b0, "events held back by mask");
      rreg(ADDR_CHST0 + 4'h3, q);
      chk(q, 16'h0000, "idle channel status");
      meas(2, -1, 1, 1);
      wreg(ADDR_CFG0 + 4'h2, 16'h0000);
      rreg(ADDR_CHST0 + 4'h2, q);
      chk(q, 16'h0000, "status cleared on disable");
      c = n_cal;
      repeat (520) @(posedge clk);
      chk(16'(n_cal - c), 16'h0, "calibration with cyclic off");
      wreg(ADDR_CTRL, 16'h0001);
      c = n_cal;
      repeat (520) @(posedge clk);
      chk(16'(n_cal - c >= 4), 16'h1, "cyclic calibration");
      rreg(ADDR_CTRL, q);
      repeat (290) @(posedge clk);
      #1;
      chk(proc_rst, 1'b0, "watchdog early");
      repeat (15) @(posedge clk);
      #1;
      chk(proc_rst, 1'b1, "watchdog expired");
      rreg(4'h7, q);
      repeat (2) @(posedge clk);
      #1;
      chk(proc_rst, 1'b0, "watchdog restarted");
      @(posedge clk);
      rst_n <= 1'b0;
      afe_ok <= 1'b0;
      repeat (8) @(posedge clk);
      rst_n <= 1'b1;
      quiet = 1'b1;
      repeat (505) @(posedge clk);
      #1;
      chk(status_led, 1'b0, "indicator after failed self-test");
      rreg(ADDR_CTRL, q);
      chk(q[4:1], 4'h2, "failed state");
      rreg(ADDR_IRQ_STAT, q);
      chk(q[IRQ_TEST], 1'b1, "self-test fail event");
      rreg(ADDR_IRQ_MASK, q);
      chk(q[3:0], IRQ_MASK_RST, "mask reset value");
      wreg(ADDR_CFG0, 16'h0001);
      repeat (40) @(posedge clk);
      give_verdict();
   end
endmodule // tb_rtd_channel_scan_control
